// ---- hdl/bcmf_pkg.sv ----
package bcmf_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_MATCH    = 8'h04;
   localparam logic [7:0] OFF_SEQ      = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_MODE_W     = 3;
   localparam int CTRL_ASCOND_BIT = 3;
   localparam int CTRL_W          = 4;
   localparam int MATCH_W         = 8;
   localparam int SEQ_W           = 4;
   localparam int IRQ_W           = 7;
   localparam int IRQ_DONE_BIT    = 6;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [IRQ_W-1:0]  MASK_RST = 7'h00;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Sequence modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_NONE = 3'h0,
      SEQ_AB   = 3'h1,
      SEQ_21   = 3'h2,
      SEQ_321  = 3'h3,
      SEQ_4321 = 3'h4
   } bcmf_mode_t;

endpackage : bcmf_pkg

// ---- hdl/bcmf_stage.sv ----
`timescale 1ns/1ps
module bcmf_stage (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Control
   input  wire logic clr_i,
   input  wire logic en_i,
   // Events
   input  wire logic hit_i,
   input  wire logic qual_i,
   input  wire logic next_hit_i,
   // Flag
   output logic      flag_o
);

   logic flag_ff;
   logic nxt_flag;
   logic set_w;
   logic drop_w;

   // Set on own hit, dropped when the next stage matches; set wins
   assign set_w    = en_i & hit_i & qual_i;
   assign drop_w   = clr_i | ~en_i | (next_hit_i & flag_ff);
   assign nxt_flag = set_w | (flag_ff & ~drop_w);
   assign flag_o   = flag_ff;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

endmodule : bcmf_stage

// ---- hdl/bcmf_top.sv ----
`timescale 1ns/1ps
// What this block does
// [R01] A flag records that the channel A condition of the break unit matched.
// [R02] A flag records that the channel B condition of the break unit matched.
// [R03] In numbered-condition use, channel A shows as condition 6, B as 5.
// [R04] Four flags record matches of break conditions one to four.
// [R05] In A-then-B mode a flag shows A matched while B has not yet.
// [R06] In 4-3-2-1 mode a flag shows condition 4 matched, 3 not yet.
// [R07] In 4-3-2-1 or 3-2-1 mode a flag shows 3 matched, 2 not yet.
// [R08] In 4-3-2-1, 3-2-1 or 2-1 mode a flag shows 2 matched, 1 not yet.
// [R09] The host samples the flags only while the user program runs; the block answers flag reads at any time.
// [R10] All flags clear on reprogramming or on restart of the program.
module bcmf_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              CLK_I,
   input  wire logic              RSTN_I,
   // Break unit events
   input  wire logic              CHA_HIT_I,
   input  wire logic              CHB_HIT_I,
   input  wire logic [3:0]        COND_HIT_I,
   input  wire logic              RUN_START_I,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // Interrupt
   output logic                   IRQ_O
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      return w;
   endfunction : word_addr

   function automatic logic [2:0] mode_top(input logic [2:0] m);
      logic [2:0] t;
      t = 3'h0;
      if (m == bcmf_pkg::SEQ_21) begin
         t = 3'h2;
      end
      if (m == bcmf_pkg::SEQ_321) begin
         t = 3'h3;
      end
      if (m == bcmf_pkg::SEQ_4321) begin
         t = 3'h4;
      end
      return t;
   endfunction : mode_top

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                      awready_ff;
   logic                      wready_ff;
   logic                      bvalid_ff;
   logic [1:0]                bresp_ff;
   logic                      arready_ff;
   logic                      rvalid_ff;
   logic [31:0]               rdata_ff;
   logic [1:0]                rresp_ff;
   logic                      irq_ff;
   logic                      aw_got_ff;
   logic [ADDR_W-1:0]         awaddr_ff;
   logic                      w_got_ff;
   logic [31:0]               wdata_ff;
   logic                      wstrb0_ff;
   logic [bcmf_pkg::CTRL_W-1:0] ctrl_ff;
   logic [bcmf_pkg::IRQ_W-1:0]  stat_ff;
   logic [bcmf_pkg::IRQ_W-1:0]  mask_ff;
   logic                      cha_mf_ff;
   logic                      chb_mf_ff;
   logic [3:0]                cond_mf_ff;

   logic                      aw_take;
   logic                      w_take;
   logic                      aw_have;
   logic                      w_have;
   logic                      do_wr;
   logic [ADDR_W-1:0]         wr_addr;
   logic [31:0]               wr_data;
   logic                      wr_lane0;
   logic [7:0]                wr_word;
   logic                      wr_ctrl;
   logic                      wr_stat;
   logic                      wr_mask;
   logic                      wr_hit;
   logic                      nxt_aw_got;
   logic                      nxt_w_got;
   logic                      nxt_bvalid;
   logic                      ar_take;
   logic                      nxt_rvalid;
   logic [7:0]                rd_word;
   logic                      rd_hit;
   logic [31:0]               rd_data;

   logic [2:0]                mode;
   logic [2:0]                top;
   logic                      as_cond;
   logic                      flag_clr;
   logic [4:0]                cond_mf_ext;
   logic [4:2]                stage_en;
   logic [4:2]                stage_qual;
   logic [4:2]                seq_cond;
   logic                      seq_cha;
   logic                      seq_done;
   logic [bcmf_pkg::MATCH_W-1:0] match_view;
   logic [5:0]                num_cond;
   logic [bcmf_pkg::SEQ_W-1:0]   seq_view;
   logic [bcmf_pkg::IRQ_W-1:0]   irq_evt;
   logic [bcmf_pkg::IRQ_W-1:0]   nxt_stat;
   logic [bcmf_pkg::IRQ_W-1:0]   nxt_mask;
   logic [bcmf_pkg::CTRL_W-1:0]  nxt_ctrl;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign aw_take    = S_AXI_AWVALID & awready_ff;
   assign w_take     = S_AXI_WVALID & wready_ff;
   assign aw_have    = aw_got_ff | aw_take;
   assign w_have     = w_got_ff | w_take;
   assign do_wr      = aw_have & w_have & ~bvalid_ff;
   assign wr_addr    = aw_take ? S_AXI_AWADDR : awaddr_ff;
   assign wr_data    = w_take ? S_AXI_WDATA : wdata_ff;
   assign wr_lane0   = w_take ? S_AXI_WSTRB[0] : wstrb0_ff;
   assign wr_word    = word_addr(wr_addr);
   assign nxt_aw_got = aw_have & ~do_wr;
   assign nxt_w_got  = w_have & ~do_wr;
   assign nxt_bvalid = do_wr | (bvalid_ff & ~S_AXI_BREADY);

   assign wr_ctrl = do_wr & wr_lane0 & (wr_word == bcmf_pkg::OFF_CTRL);
   assign wr_stat = do_wr & wr_lane0 & (wr_word == bcmf_pkg::OFF_IRQ_STAT);
   assign wr_mask = do_wr & wr_lane0 & (wr_word == bcmf_pkg::OFF_IRQ_MASK);
   assign wr_hit  = (wr_word == bcmf_pkg::OFF_CTRL)
                  | (wr_word == bcmf_pkg::OFF_MATCH)
                  | (wr_word == bcmf_pkg::OFF_SEQ)
                  | (wr_word == bcmf_pkg::OFF_IRQ_STAT)
                  | (wr_word == bcmf_pkg::OFF_IRQ_MASK);

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= bcmf_pkg::RESP_OKAY;
      end else begin
         aw_got_ff  <= nxt_aw_got;
         w_got_ff   <= nxt_w_got;
         awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
         wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
         bvalid_ff  <= nxt_bvalid;
         if (do_wr) begin
            bresp_ff <= wr_hit ? bcmf_pkg::RESP_OKAY : bcmf_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         awaddr_ff <= '0;
         wdata_ff  <= 32'h00000000;
         wstrb0_ff <= 1'b0;
      end else begin
         if (aw_take) begin
            awaddr_ff <= S_AXI_AWADDR;
         end
         if (w_take) begin
            wdata_ff  <= S_AXI_WDATA;
            wstrb0_ff <= S_AXI_WSTRB[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign ar_take    = S_AXI_ARVALID & arready_ff;
   assign nxt_rvalid = ar_take | (rvalid_ff & ~S_AXI_RREADY);
   assign rd_word    = word_addr(S_AXI_ARADDR);
   assign rd_hit     = (rd_word == bcmf_pkg::OFF_CTRL)
                     | (rd_word == bcmf_pkg::OFF_MATCH)
                     | (rd_word == bcmf_pkg::OFF_SEQ)
                     | (rd_word == bcmf_pkg::OFF_IRQ_STAT)
                     | (rd_word == bcmf_pkg::OFF_IRQ_MASK);
   assign rd_data =
      (rd_word == bcmf_pkg::OFF_CTRL)     ? {28'h0000000, ctrl_ff}    :
      (rd_word == bcmf_pkg::OFF_MATCH)    ? {24'h000000, match_view}  :
      (rd_word == bcmf_pkg::OFF_SEQ)      ? {28'h0000000, seq_view}   :
      (rd_word == bcmf_pkg::OFF_IRQ_STAT) ? {25'h0000000, stat_ff}    :
      (rd_word == bcmf_pkg::OFF_IRQ_MASK) ? {25'h0000000, mask_ff}    :
      32'h00000000;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= bcmf_pkg::RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff  <= nxt_rvalid;
         if (ar_take) begin
            rdata_ff <= rd_data;
            rresp_ff <= rd_hit ? bcmf_pkg::RESP_OKAY : bcmf_pkg::RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   assign nxt_ctrl = wr_ctrl ? wr_data[bcmf_pkg::CTRL_W-1:0] : ctrl_ff;
   assign mode     = ctrl_ff[bcmf_pkg::CTRL_MODE_LSB +: bcmf_pkg::CTRL_MODE_W];
   assign as_cond  = ctrl_ff[bcmf_pkg::CTRL_ASCOND_BIT];
   assign top      = mode_top(mode);
   // [R10] Clear on reprogram
   assign flag_clr = wr_ctrl | RUN_START_I;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctrl_ff <= bcmf_pkg::CTRL_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // ----------------------------------------------------------------
   // Plain match flags
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cha_mf_ff  <= 1'b0;
         chb_mf_ff  <= 1'b0;
         cond_mf_ff <= 4'h0;
      end else begin
         // [R01] Channel A flag
         cha_mf_ff  <= CHA_HIT_I | (cha_mf_ff & ~flag_clr);
         // [R02] Channel B flag
         chb_mf_ff  <= CHB_HIT_I | (chb_mf_ff & ~flag_clr);
         // [R04] Condition flags
         cond_mf_ff <= COND_HIT_I | (cond_mf_ff & ~{4{flag_clr}});
      end
   end

   // [R03] Numbered condition view
   assign num_cond   = {as_cond & cha_mf_ff, as_cond & chb_mf_ff, cond_mf_ff};
   assign match_view = {num_cond, chb_mf_ff, cha_mf_ff};

   // ----------------------------------------------------------------
   // Sequential stage flags
   // ----------------------------------------------------------------
   assign cond_mf_ext = {1'b0, cond_mf_ff};

   // [R05] Channel A before B
   bcmf_stage u_stage_cha (
      .clk_i      (CLK_I),
      .rstn_i     (RSTN_I),
      .clr_i      (flag_clr),
      .en_i       (mode == bcmf_pkg::SEQ_AB),
      .hit_i      (CHA_HIT_I),
      .qual_i     (1'b1),
      .next_hit_i (CHB_HIT_I),
      .flag_o     (seq_cha)
   );

   generate
      for (genvar k = 2; k <= 4; k++) begin : g_stage
         // [R06] [R07] [R08] Stage enable per mode
         assign stage_en[k]   = (top >= 3'(k));
         assign stage_qual[k] = (top == 3'(k)) | cond_mf_ext[k];
         bcmf_stage u_stage (
            .clk_i      (CLK_I),
            .rstn_i     (RSTN_I),
            .clr_i      (flag_clr),
            .en_i       (stage_en[k]),
            .hit_i      (COND_HIT_I[k-1]),
            .qual_i     (stage_qual[k]),
            .next_hit_i (COND_HIT_I[k-2]),
            .flag_o     (seq_cond[k])
         );
      end
   endgenerate

   assign seq_view = {seq_cond, seq_cha};
   assign seq_done = (seq_cha & CHB_HIT_I)
                   | (stage_en[2] & seq_cond[2] & COND_HIT_I[0]);

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   assign irq_evt  = {seq_done, COND_HIT_I, CHB_HIT_I, CHA_HIT_I};
   // Set wins over write-one-to-clear
   assign nxt_stat = irq_evt
                   | (stat_ff & ~({bcmf_pkg::IRQ_W{wr_stat}}
                                  & wr_data[bcmf_pkg::IRQ_W-1:0]));
   assign nxt_mask = wr_mask ? wr_data[bcmf_pkg::IRQ_W-1:0] : mask_ff;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         stat_ff <= '0;
         mask_ff <= bcmf_pkg::MASK_RST;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff  <= |(nxt_stat & nxt_mask);
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY  = wready_ff;
   assign S_AXI_BVALID  = bvalid_ff;
   assign S_AXI_BRESP   = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID  = rvalid_ff;
   assign S_AXI_RDATA   = rdata_ff;
   assign S_AXI_RRESP   = rresp_ff;
   assign IRQ_O         = irq_ff;

endmodule : bcmf_top

// ---- tb/bcmf_asserts.sv ----
`timescale 1ns/1ps
module bcmf_asserts #(
   parameter int ADDR_W = 8
) (
   // Clock, reset, events
   input  wire logic              CLK_I, RSTN_I, CHA_HIT_I, CHB_HIT_I,
   input  wire logic [3:0]        COND_HIT_I,
   // Register bus
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY, S_AXI_AWVALID, S_AXI_AWREADY,
   input  wire logic              S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY, IRQ_O,
   input  wire logic [31:0]       S_AXI_RDATA,
   input  wire logic [1:0]        S_AXI_RRESP
);
   logic ev;
   assign ev = CHA_HIT_I || CHB_HIT_I || (|COND_HIT_I)
               || (S_AXI_WVALID && S_AXI_WREADY);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence ar_take; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
   sequence r_beat; S_AXI_RVALID && S_AXI_RREADY ##1 !S_AXI_RVALID; endsequence
   rd_answer_a: assert property (ar_take |=> r_beat)
      else $error("read not answered next cycle");
   rd_release_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data held after handshake");
   ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address accepted while data pending");
   rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
   irq_cause_a: assert property ($rose(IRQ_O) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3))
      else $error("interrupt rose without an event");
   wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
      else $error("write not answered next cycle");
   wr_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response held after handshake");
   wr_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while response pending");
   map_err_a: assert property (ar_take and S_AXI_ARADDR > 'h10 |=> S_AXI_RRESP == bcmf_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
      else $error("unmapped read not refused");
endmodule : bcmf_asserts
bind bcmf_top bcmf_asserts #(.ADDR_W(ADDR_W)) u_bcmf_asserts (.CLK_I, .RSTN_I,
   .CHA_HIT_I, .CHB_HIT_I, .COND_HIT_I, .S_AXI_ARADDR, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .IRQ_O,
   .S_AXI_RDATA, .S_AXI_RRESP);

// ---- tb/bcmf_host.sv ----
`timescale 1ns/1ps
module bcmf_host (
   // Clock
   input  wire logic        clk_i,
   // Requests
   output logic [7:0]       awaddr_o, araddr_o,
   output logic [31:0]      wdata_o,
   output logic [3:0]       wstrb_o,
   output logic             awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o,
   // Answers
   input  wire logic        awready_i, wready_i, bvalid_i, arready_i, rvalid_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  bresp_i, rresp_i
);
   initial begin
      {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
      {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_i);
      awaddr_o <= a;
      wdata_o <= d;
      wstrb_o <= 4'hF;
      {awvalid_o, wvalid_o, bready_o} <= 3'h7;
      do begin
         @(posedge clk_i);
         if (awready_i) awvalid_o <= 1'b0;
         if (wready_i) wvalid_o <= 1'b0;
      end while (!bvalid_i);
      r = bresp_i;
      bready_o <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_i);
      araddr_o <= a;
      {arvalid_o, rready_o} <= 2'h3;
      do begin
         @(posedge clk_i);
         if (arready_i) arvalid_o <= 1'b0;
      end while (!rvalid_i);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
   endtask : rd
endmodule : bcmf_host

// ---- tb/bcmf_top_tb.sv ----
`timescale 1ns/1ps
module bcmf_top_tb;
   logic        clk = 1'b0, rstn = 1'b0, cha = 1'b0, chb = 1'b0, run = 1'b0;
   logic [3:0]  cond = 4'h0, wstrb_o;
   logic [7:0]  awaddr_o, araddr_o;
   logic [31:0] wdata_o, rdata_i, rd_d;
   logic [1:0]  bresp_i, rresp_i, rd_r;
   logic        awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o, irq;
   logic        awready_i, wready_i, bvalid_i, arready_i, rvalid_i;
   int          num_errors = 0, total_checks = 0, cyc = 0;
   localparam logic [1:0] OK = bcmf_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = bcmf_pkg::RESP_SLVERR;
   always #10 clk = ~clk;
   bcmf_top u_bcmf_top (.CLK_I(clk), .RSTN_I(rstn), .CHA_HIT_I(cha),
      .CHB_HIT_I(chb), .COND_HIT_I(cond), .RUN_START_I(run),
      .S_AXI_AWADDR(awaddr_o), .S_AXI_AWVALID(awvalid_o),
      .S_AXI_AWREADY(awready_i), .S_AXI_WDATA(wdata_o), .S_AXI_WSTRB(wstrb_o),
      .S_AXI_WVALID(wvalid_o), .S_AXI_WREADY(wready_i), .S_AXI_BRESP(bresp_i),
      .S_AXI_BVALID(bvalid_i), .S_AXI_BREADY(bready_o),
      .S_AXI_ARADDR(araddr_o), .S_AXI_ARVALID(arvalid_o),
      .S_AXI_ARREADY(arready_i), .S_AXI_RDATA(rdata_i), .S_AXI_RRESP(rresp_i),
      .S_AXI_RVALID(rvalid_i), .S_AXI_RREADY(rready_o), .IRQ_O(irq));
   bcmf_host host (.clk_i(clk), .awaddr_o, .araddr_o, .wdata_o, .wstrb_o,
      .awvalid_o, .wvalid_o, .bready_o, .arvalid_o, .rready_o, .awready_i,
      .wready_i, .bvalid_i, .arready_i, .rvalid_i, .rdata_i, .bresp_i, .rresp_i);
   task automatic give_verdict();
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = OK);
      host.rd(a, rd_d, rd_r);
      cmp(rd_d, e);
      cmp({30'h0, rd_r}, {30'h0, er});
   endtask : rc
   task automatic wc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = OK);
      host.wr(a, d, rd_r);
      cmp({30'h0, rd_r}, {30'h0, er});
   endtask : wc
   task automatic hit(input logic a, input logic b, input logic [3:0] c);
      @(posedge clk);
      {cha, chb, cond} <= {a, b, c};
      @(posedge clk);
      {cha, chb, cond} <= 6'h00;
   endtask : hit
   // Condition hits in nibble order, sequence flags read after each
   task automatic seq_run(input logic [3:0] m, input logic [23:0] h,
                          input logic [23:0] e, input int n);
      wc(bcmf_pkg::OFF_CTRL, {28'h0, m});
      for (int i = 0; i < n; i++) begin
         hit(1'b0, 1'b0, h[4*i+:4]);
         rc(bcmf_pkg::OFF_SEQ, {28'h0, e[4*i+:4]});
      end
   endtask : seq_run
   task automatic irq_is(input logic v);
      @(negedge clk);
      cmp({31'h0, irq}, {31'h0, v});
   endtask : irq_is
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rc(bcmf_pkg::OFF_MATCH, 32'h0);
      rc(bcmf_pkg::OFF_SEQ, 32'h0);
      rc(bcmf_pkg::OFF_IRQ_MASK, 32'h0);
      rc(8'h14, 32'h0, ERR);
      wc(8'h14, 32'h1, ERR);
      wc(bcmf_pkg::OFF_CTRL, 32'h8);
      hit(1'b1, 1'b0, 4'h0);
      rc(bcmf_pkg::OFF_MATCH, 32'h81);
      rc(bcmf_pkg::OFF_SEQ, 32'h0);
      hit(1'b0, 1'b1, 4'h5);
      rc(bcmf_pkg::OFF_MATCH, 32'hD7);
      @(posedge clk);
      run <= 1'b1;
      @(posedge clk);
      run <= 1'b0;
      rc(bcmf_pkg::OFF_MATCH, 32'h0);
      hit(1'b0, 1'b0, 4'hA);
      rc(bcmf_pkg::OFF_MATCH, 32'h28);
      wc(bcmf_pkg::OFF_CTRL, 32'h1);
      rc(bcmf_pkg::OFF_MATCH, 32'h0);
      hit(1'b1, 1'b0, 4'h0);
      rc(bcmf_pkg::OFF_SEQ, 32'h1);
      hit(1'b0, 1'b1, 4'h0);
      rc(bcmf_pkg::OFF_SEQ, 32'h0);
      seq_run(4'h4, 24'h128484, 24'h8AC480, 6);
      rc(bcmf_pkg::OFF_IRQ_STAT, 32'h7F);
      irq_is(1'b0);
      wc(bcmf_pkg::OFF_IRQ_MASK, 32'h40);
      irq_is(1'b1);
      wc(bcmf_pkg::OFF_IRQ_STAT, 32'h40);
      irq_is(1'b0);
      rc(bcmf_pkg::OFF_IRQ_STAT, 32'h3F);
      hit(1'b0, 1'b0, 4'h1);
      irq_is(1'b0);
      wc(bcmf_pkg::OFF_IRQ_MASK, 32'h7F);
      irq_is(1'b1);
      seq_run(4'h2, 24'h001248, 24'h000200, 4);
      seq_run(4'h3, 24'h002482, 24'h002400, 4);
      give_verdict();
   end
endmodule : bcmf_top_tb
